// ==== rtl/irap_engine.sv ====
`timescale 1ns/1ps
// one block's indirect array with a fixed-latency access sequence
module irap_engine
  import irap_pkg::*;
(
  input  wire logic   i_clk,
  input  wire logic   i_rst_b,
  irap_engine_if.eng  io_eng
);
  import irap_pkg::*;

  typedef enum logic [1:0] {
    IRAP_IDLE = 2'b01,
    IRAP_RUN  = 2'b10
  } irap_state_e;

  logic [DATA_W-1:0]     mem [0:(1<<IND_ADDR_W)-1];
  irap_state_e           state_reg,  state_next;
  logic [CNT_W-1:0]      cnt_reg,    cnt_next;
  logic                  rnw_reg,    rnw_next;
  logic [IND_ADDR_W-1:0] addr_reg,   addr_next;
  logic [DATA_W-1:0]     wdat_reg,   wdat_next;
  logic [DATA_W-1:0]     rdat_reg,   rdat_next;
  logic                  done_reg,   done_next;
  logic                  mem_we;

  // sequence: start latches the request, finishes after ACCESS_CYC
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    rnw_next   = rnw_reg;
    addr_next  = addr_reg;
    wdat_next  = wdat_reg;
    rdat_next  = rdat_reg;
    done_next  = 1'b0;
    mem_we     = 1'b0;
    case (state_reg)
      IRAP_IDLE: begin
        if (io_eng.start) begin // RL3 RL7
          state_next = IRAP_RUN;
          cnt_next   = CNT_W'(ACCESS_CYC - 1);
          rnw_next   = io_eng.rnw;
          addr_next  = io_eng.addr;
          wdat_next  = io_eng.wdata;
        end
      end
      IRAP_RUN: begin
        if (cnt_reg == '0) begin // RL8
          state_next = IRAP_IDLE;
          done_next  = 1'b1;
          if (rnw_reg) begin
            rdat_next = mem[addr_reg]; // RL5
          end else begin
            mem_we = 1'b1; // RL7
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: state_next = IRAP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= IRAP_IDLE;
      cnt_reg   <= '0;
      rnw_reg   <= 1'b0;
      addr_reg  <= '0;
      wdat_reg  <= DATA_RST;
      rdat_reg  <= DATA_RST;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      rnw_reg   <= rnw_next;
      addr_reg  <= addr_next;
      wdat_reg  <= wdat_next;
      rdat_reg  <= rdat_next;
      done_reg  <= done_next;
    end
  end

  // array has no reset: contents are undefined until software loads them
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[addr_reg] <= wdat_reg;
    end
  end

  assign io_eng.busy  = (state_reg == IRAP_RUN); // RL13
  assign io_eng.done  = done_reg;
  assign io_eng.rdata = rdat_reg;
endmodule : irap_engine

// ==== rtl/irap_engine_if.sv ====
`timescale 1ns/1ps
// one indirect access engine: request fields plus busy/done/rdata handshake
interface irap_engine_if;
  logic       start;
  logic       rnw;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       busy;
  logic       done;
  logic [7:0] rdata;
  modport ctrl (output start, rnw, addr, wdata, input busy, done, rdata);
  modport eng  (input start, rnw, addr, wdata, output busy, done, rdata);
endinterface : irap_engine_if

// ==== rtl/irap_pkg.sv ====
package irap_pkg;
  localparam int          ADDR_W       = 10;
  localparam int          DATA_W       = 8;
  localparam int          IND_ADDR_W   = 7;
  localparam int          NUM_LINKS    = 4;
  localparam int          NUM_BLOCKS   = 3;
  // link select is the leading hex digit of the 10-bit offset
  localparam int          LINK_MSB     = 9;
  localparam int          LINK_LSB     = 8;
  // per-link offsets (low byte)
  localparam logic [7:0]  OFF_TX_STAT  = 8'hC8;
  localparam logic [7:0]  OFF_TX_CTRL  = 8'hC9;
  localparam logic [7:0]  OFF_TX_DATA  = 8'hCA;
  localparam logic [7:0]  OFF_RX_STAT  = 8'hCD;
  localparam logic [7:0]  OFF_RX_CTRL  = 8'hCE;
  localparam logic [7:0]  OFF_RX_DATA  = 8'hCF;
  localparam logic [7:0]  OFF_SIG_STAT = 8'hD3;
  localparam logic [7:0]  OFF_SIG_CTRL = 8'hD4;
  localparam logic [7:0]  OFF_SIG_DATA = 8'hD5;
  // field positions and reset values
  localparam int          RNW_BIT      = 7;
  localparam int          BUSY_BIT     = 0;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  // block index within a link
  localparam logic [1:0]  BLK_TX       = 2'h0;
  localparam logic [1:0]  BLK_RX       = 2'h1;
  localparam logic [1:0]  BLK_SIG      = 2'h2;
  // completion bound
  localparam int          CLK_PERIOD_PS = 8000;
  localparam int          DONE_MAX_NS   = 4000;
  localparam int          DONE_MAX_CYC  = (DONE_MAX_NS * 1000) / CLK_PERIOD_PS;
  // cycles an engine spends before finishing, well inside the bound
  localparam int          ACCESS_CYC    = 4;
  localparam int          CNT_W         = 3;
endpackage : irap_pkg

// ==== rtl/irap_top.sv ====
`timescale 1ns/1ps
// Behaviour
// RL1 - per-channel arrays reached only indirectly
// RL2 - host checks busy clear before reading
// RL3 - control write with read flag starts read
// RL4 - host polls busy clear before using data
// RL5 - after read, data register holds array value
// RL6 - host checks busy, then loads data register
// RL7 - control write with write flag stores data
// RL8 - each access finishes within four microseconds
// RL9 - status registers at C8, CD, D3
// RL10 - control holds flag and 7-bit address
// RL11 - data registers at CA, CF, D5
// RL12 - four links selected by leading digit
// RL13 - top bit one reads; busy set to finish
module irap_top
  import irap_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  input  wire logic [irap_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [irap_pkg::DATA_W-1:0] i_wdata,
  output      logic [irap_pkg::DATA_W-1:0] o_rdata,
  output      logic                      o_hit
);
  import irap_pkg::*;

  localparam int NENG = NUM_LINKS * NUM_BLOCKS;

  // decode a low offset into block index and register kind
  // kind: 0 status, 1 control, 2 data, 3 none
  function automatic logic [3:0] reg_decode(input logic [7:0] off);
    logic [3:0] r;
    r = 4'hF;
    case (off)
      OFF_TX_STAT:  r = {BLK_TX,  2'h0}; // RL9
      OFF_TX_CTRL:  r = {BLK_TX,  2'h1}; // RL10
      OFF_TX_DATA:  r = {BLK_TX,  2'h2}; // RL11
      OFF_RX_STAT:  r = {BLK_RX,  2'h0}; // RL9
      OFF_RX_CTRL:  r = {BLK_RX,  2'h1}; // RL10
      OFF_RX_DATA:  r = {BLK_RX,  2'h2}; // RL11
      OFF_SIG_STAT: r = {BLK_SIG, 2'h0}; // RL9
      OFF_SIG_CTRL: r = {BLK_SIG, 2'h1};
      OFF_SIG_DATA: r = {BLK_SIG, 2'h2}; // RL11
      default:      r = 4'hF;
    endcase
    return r;
  endfunction : reg_decode

  logic [3:0] dec;
  logic [1:0] link;
  logic [1:0] blk;
  logic [1:0] kind;
  logic       mapped;
  logic [3:0] sel;

  // link comes from the top address digit
  always_comb begin
    dec    = reg_decode(i_addr[7:0]);
    link   = i_addr[LINK_MSB:LINK_LSB]; // RL12
    blk    = dec[3:2];
    kind   = dec[1:0];
    mapped = (kind != 2'h3) && (blk != 2'h3);
    sel    = 4'(link * NUM_BLOCKS + blk);
  end

  logic [DATA_W-1:0] ctrl_reg [NENG];
  logic [DATA_W-1:0] ctrl_next[NENG];
  logic [DATA_W-1:0] data_reg [NENG];
  logic [DATA_W-1:0] data_next[NENG];
  logic [DATA_W-1:0] rd_mux   [NENG];

  // the arrays sit behind the engines; no direct path exists (RL1)
  genvar g;
  generate
    for (g = 0; g < NENG; g++) begin : g_eng
      irap_engine_if eif ();
      logic hit_g;
      logic ctrl_wr;
      logic data_wr;

      always_comb begin
        hit_g   = mapped && (sel == 4'(g));
        ctrl_wr = i_wr && hit_g && (kind == 2'h1);
        data_wr = i_wr && hit_g && (kind == 2'h2);
      end

      // control write latches flag/address and kicks the engine
      always_comb begin
        ctrl_next[g] = ctrl_reg[g];
        if (ctrl_wr && !eif.busy) begin
          ctrl_next[g] = i_wdata; // RL10
        end
      end

      // returned read data wins over a host write landing in the same
      // cycle, since the host must not write while busy anyway; only a
      // finished read loads it, so a finished write keeps the host value
      always_comb begin
        data_next[g] = data_reg[g];
        if (eif.done && ctrl_reg[g][RNW_BIT]) begin // RL5
          data_next[g] = eif.rdata;
        end else if (data_wr && !eif.busy) begin
          data_next[g] = i_wdata;
        end
      end

      assign eif.start = ctrl_wr && !eif.busy; // RL3 RL7
      assign eif.rnw   = i_wdata[RNW_BIT]; // RL13
      assign eif.addr  = i_wdata[IND_ADDR_W-1:0];
      assign eif.wdata = data_reg[g];

      always_comb begin
        case (kind)
          2'h0:    rd_mux[g] = {7'h00, eif.busy};
          2'h1:    rd_mux[g] = ctrl_reg[g];
          2'h2:    rd_mux[g] = data_reg[g];
          default: rd_mux[g] = 8'h00;
        endcase
      end

      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          ctrl_reg[g] <= CTRL_RST;
          data_reg[g] <= DATA_RST;
        end else begin
          ctrl_reg[g] <= ctrl_next[g];
          data_reg[g] <= data_next[g];
        end
      end

      irap_engine u_eng (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .io_eng  (eif.eng)
      );
    end
  endgenerate

  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              hit_reg,   hit_next;

  // read data registered one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    hit_next   = 1'b0;
    if ((i_rd || i_wr) && mapped) begin
      hit_next = 1'b1;
    end
    if (i_rd && mapped) begin
      rdata_next = rd_mux[sel];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 8'h00;
      hit_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      hit_reg   <= hit_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_hit   = hit_reg;
endmodule : irap_top

// ==== verif/irap_host_model.sv ====
`timescale 1ns/1ps
// host side: one access at a time, launched on the falling edge
module irap_host_model
  import irap_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output      logic       o_wr,
  output      logic       o_rd,
  output      logic [9:0] o_addr,
  output      logic [7:0] o_wdata
);
  // released lines carry the inverse of their last value, never a copy
  initial {o_wr, o_rd, o_addr, o_wdata} = 20'h00000;
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge i_clk);
    {o_rd, o_addr} = {1'b1, a};
    repeat (2) @(negedge i_clk);
    d = i_rdata;
    {o_rd, o_addr} = {1'b0, ~a};
  endtask : rd
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, v};
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~v};
  endtask : wr
  // polls until busy reads 0, bounded; f keeps the first byte seen
  task automatic poll(input logic [9:0] s, output int n, output logic [7:0] f);
    logic [7:0] d;
    d = 8'h01;
    for (n = 0; d[BUSY_BIT] !== 1'b0 && n < 400; n++) begin
      rd(s, d);
      if (n == 0) f = d;
    end
  endtask : poll
  // s is the status offset; control and data follow it
  task automatic iacc(input logic [9:0] s, input logic [7:0] cw, v,
                      output logic [7:0] d, f, output int n);
    poll(s, n, f);
    if (!cw[RNW_BIT]) wr(s + 10'h002, v);
    wr(s + 10'h001, cw);
    poll(s, n, f);
    if (cw[RNW_BIT]) rd(s + 10'h002, d);
  endtask : iacc
endmodule : irap_host_model

// ==== verif/irap_top_monitor.sv ====
`timescale 1ns/1ps
// passive watch of the host port; shadows the last control write only
module irap_top_monitor
  import irap_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_hit
);
  logic [9:0] cnt_reg, cnt_next, ca_reg, ca_next;
  logic [7:0] cv_reg, cv_next, lo;
  logic       rd_reg, rd_next, r2, st, ct, mp, nb, bz;
  // r2: second cycle of a held read; nb: poll two cycles after a start
  assign lo = i_addr[7:0];
  assign st = lo==OFF_TX_STAT || lo==OFF_RX_STAT || lo==OFF_SIG_STAT;
  assign ct = lo==OFF_TX_CTRL || lo==OFF_RX_CTRL || lo==OFF_SIG_CTRL;
  assign mp = st | ct | lo==OFF_TX_DATA | lo==OFF_RX_DATA | lo==OFF_SIG_DATA;
  assign r2 = i_rd && rd_reg;
  assign nb = r2 && st && cnt_reg == 10'h002 && i_addr == ca_reg - 10'h001;
  assign bz = o_rdata[BUSY_BIT];
  // age saturates so a long-idle port never looks freshly started
  always_comb begin
    rd_next  = i_rd;
    cnt_next = (cnt_reg == 10'h3FF) ? cnt_reg : cnt_reg + 10'h001;
    ca_next  = ca_reg;
    cv_next  = cv_reg;
    if (i_wr && ct) begin
      cnt_next = 10'h000;
      ca_next  = i_addr;
      cv_next  = i_wdata;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_reg  <= 1'b0;
      cnt_reg <= 10'h3FF;
      ca_reg  <= 10'h000;
      cv_reg  <= 8'h00;
    end else begin
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      ca_reg  <= ca_next;
      cv_reg  <= cv_next;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_stat_rsvd: assert property (r2 && st |-> o_rdata[7:1] == 7'h00)
    else $error("status spare bits set");
  chk_hit_map: assert property (r2 && mp |-> o_hit)
    else $error("mapped read missed");
  chk_hit_none: assert property (r2 && !mp |-> !o_hit)
    else $error("unmapped read hit");
  chk_link_top: assert property (r2 && mp && &i_addr[9:8] |-> o_hit)
    else $error("top link read missed");
  chk_rd_busy: assert property (nb && cv_reg[RNW_BIT] |-> bz)
    else $error("read start not busy");
  chk_wr_busy: assert property (nb && !cv_reg[RNW_BIT] |-> bz)
    else $error("write start not busy");
  chk_busy_done: assert property (
    r2 && st && cnt_reg >= DONE_MAX_CYC |-> !bz) else $error("busy stuck");
  chk_ctrl_back: assert property (
    r2 && ct && i_addr == ca_reg |-> o_rdata == cv_reg) else $error("ctrl lost");
endmodule : irap_top_monitor
bind irap_top irap_top_monitor u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_hit(o_hit));

// ==== verif/irap_top_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: %0h vs %0h", $time, g, e); end end
module irap_top_test;
  import irap_pkg::*;
  localparam logic [7:0] SO [3] = '{OFF_TX_STAT, OFF_RX_STAT, OFF_SIG_STAT};
  logic       i_clk, i_rst_b, wr, rd, hit;
  logic [9:0] addr, s;
  logic [7:0] wdata, rdata, d, f, v;
  logic [6:0] ia;
  int         checks, mismatches, n;
  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;
  irap_top uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_hit(hit));
  irap_host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (checks > 0 && mismatches == 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // tests need about 950 cycles; allow about thirteen times that
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  // slot i: link i/3, block i%3, indirect address at either end
  function automatic void slot(input int i);
    s  = {2'(i / 3), SO[i % 3]};
    ia = i[0] ? 7'h00 : 7'h7F;
    v  = 8'(i * 19 + 8'h81);
  endfunction : slot
  initial begin
    i_rst_b = 1'b0;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk) i_rst_b = 1'b1;
    host.rd(10'h0C9, d);
    `CHK(d, CTRL_RST)
    host.rd(10'h3D5, d);
    `CHK(d, DATA_RST)
    `CHK(hit, 1'b1)
    host.rd(10'h0C7, d);
    `CHK(hit, 1'b0)
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      slot(i);
      host.iacc(s, {1'b0, ia}, v, d, f, n);
      `CHK(f[BUSY_BIT], 1'b1)
      `CHK(n * 3 <= DONE_MAX_CYC, 1'b1)
    end
    $display("test writes done");
    repeat (520) @(negedge i_clk);
    for (int i = 0; i < 12; i++) begin
      slot(i);
      host.wr(s, 8'hFF);
      host.rd(s, d);
      `CHK(d, 8'h00)
    end
    $display("test status done");
    for (int i = 0; i < 12; i++) begin
      slot(i);
      host.iacc(s, {1'b1, ia}, 8'h00, d, f, n);
      `CHK(d, v)
      host.rd(s + 10'h001, d);
      `CHK(d, {1'b1, ia})
    end
    $display("test reads done");
    print_verdict();
  end
endmodule : irap_top_test
